// ### hw/ctr_defs.svh
// Constants for the clock trim and reset source block.
`ifndef CTR_DEFS_SVH
`define CTR_DEFS_SVH
`define CTR_AW 8
`define CTR_DW 16
`define CTR_ADDR_TRIM 8'h00
`define CTR_ADDR_BASE 8'h04
`define CTR_ADDR_CAL 8'h08
`define CTR_ADDR_FLAGS 8'h0C
`define CTR_ADDR_IST 8'h10
`define CTR_ADDR_IMSK 8'h14
`define CTR_TRIM_W 5
`define CTR_BASE_W 7
`define CTR_CAL_W 14
`define CTR_FLAG_TO 0
`define CTR_FLAG_PD 1
`define CTR_FLAG_ST 4
`define CTR_EV_W 6
`define CTR_EV_POR 0
`define CTR_EV_PIN 1
`define CTR_EV_WDT 2
`define CTR_EV_WAKE 3
`define CTR_EV_HOT 4
`define CTR_EV_TRIM 5
`define CTR_CLK_MHZ 40
`define CTR_BASE_MHZ 8
`define CTR_SETTLE_NS 10000
`define CTR_SETTLE_CYC ((`CTR_SETTLE_NS * `CTR_CLK_MHZ + 999) / 1000)
`define CTR_SUPPLY_SETTLE_TIMER_MS 64
`define CTR_SUPPLY_SETTLE_TIMER_CYC (`CTR_SUPPLY_SETTLE_TIMER_MS * `CTR_CLK_MHZ * 1000)
`define CTR_CNT_W 22
`define CTR_TRIM_STEP 5
`define CTR_PIN_FILT 8
`endif

// ### hw/ctr_pkg.sv
// Types shared by the clock trim and reset source block.
package ctr_pkg;
    typedef enum logic [3:0] {
        CTR_ST_POR = 4'b0001,
        CTR_ST_RST = 4'b0010,
        CTR_ST_SETTLE = 4'b0100,
        CTR_ST_RUN = 4'b1000
    } ctr_state_t;
endpackage : ctr_pkg

// ### hw/ctr_pin_filter.sv
// Three-stage synchroniser with a pulse width filter for a raw pin.
`timescale 1ns/1ps
`include "ctr_defs.svh"
module ctr_pin_filter #(
    parameter int FILT_CYC = `CTR_PIN_FILT,
    parameter logic INIT = 1'b1
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic [7:0] cnt_r;

    // Plain synchroniser chain; only the second and third stages are judged.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A new level must hold FILT_CYC cycles, so short spikes die here.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cnt_r <= 8'h00;
            level_o <= INIT;
        end else if (s2_r != s3_r || s3_r == level_o) begin
            cnt_r <= 8'h00;
        end else if (cnt_r == 8'(FILT_CYC - 1)) begin
            cnt_r <= 8'h00;
            level_o <= s3_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule : ctr_pin_filter

// ### hw/ctr_top.sv
// Clock trim registers and reset source sequencer.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ctr_defs.svh"
module ctr_top
    import ctr_pkg::*;
#(
    parameter int SUPPLY_SETTLE_TIMER_CYC = `CTR_SUPPLY_SETTLE_TIMER_CYC,
    parameter int PIN_FILT = `CTR_PIN_FILT
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [`CTR_AW-1:0] addr_i,
    input wire logic [`CTR_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`CTR_DW-1:0] rdata_o,
    input wire logic [`CTR_CAL_W-1:0] factory_calibration_word_i,
    input wire logic external_reset_pin_n_i,
    input wire logic external_reset_pin_select_i,
    input wire logic supply_settle_timer_en_i,
    input wire logic thermal_fault_i,
    input wire logic watchdog_expire_i,
    input wire logic watchdog_clear_i,
    input wire logic sleep_enter_i,
    output logic chip_reset_o,
    output logic run_o,
    output logic [`CTR_BASE_W-1:0] clock_trim_base_o,
    output logic signed [`CTR_TRIM_W-1:0] trim_applied_o,
    output logic irq_o
);
    localparam logic [`CTR_CNT_W-1:0] SUPPLY_SETTLE_TIMER_LAST = `CTR_CNT_W'(SUPPLY_SETTLE_TIMER_CYC - 1);
    localparam logic [`CTR_CNT_W-1:0] SETTLE_LAST =
        `CTR_CNT_W'(`CTR_SETTLE_CYC - 1);
    localparam logic signed [5:0] STEP = 6'(`CTR_TRIM_STEP);

    ctr_state_t state_r;
    ctr_state_t state_nxt;
    logic [`CTR_CNT_W-1:0] cnt_r;
    logic [`CTR_TRIM_W-1:0] trim_r;
    logic [`CTR_BASE_W-1:0] base_r;
    logic signed [5:0] diff;
    logic signed [5:0] applied_nxt;
    logic to_r;
    logic pd_r;
    logic asleep_r;
    logic pin_level;
    logic hot_level;
    logic pin_rst;
    logic wdt_rst;
    logic wdt_wake;
    logic [`CTR_EV_W-1:0] ev;
    logic [`CTR_EV_W-1:0] ist_r;
    logic [`CTR_EV_W-1:0] imsk_r;
    logic [`CTR_DW-1:0] rd_nxt;
    logic wr_trim;

    // One decode shared by the write and the read paths.
    function automatic logic hit(input logic [`CTR_AW-1:0] a,
                                 input logic [`CTR_AW-1:0] r);
        hit = (a == r);
    endfunction : hit

    // The pin is sampled only; nothing in here ever drives it low.
    ctr_pin_filter #(.FILT_CYC(PIN_FILT), .INIT(1'b1)) u_pin (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .pin_i(external_reset_pin_n_i),
        .level_o(pin_level)
    );

    // Thermal fault is an analog comparator, so it gets the same sync.
    ctr_pin_filter #(.FILT_CYC(1), .INIT(1'b0)) u_hot (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .pin_i(thermal_fault_i),
        .level_o(hot_level)
    );

    // Reset causes; the pin counts only when it is selected as reset.
    assign pin_rst = external_reset_pin_select_i & ~pin_level;
    assign wdt_rst = watchdog_expire_i & ~asleep_r;
    assign wdt_wake = watchdog_expire_i & asleep_r;

    // Sequencer: power-on hold, source reset, memory settle, run.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CTR_ST_POR: begin
                if ((!supply_settle_timer_en_i || cnt_r == SUPPLY_SETTLE_TIMER_LAST)
                    && !pin_rst && !hot_level) begin
                    state_nxt = CTR_ST_SETTLE;
                end
            end
            CTR_ST_RST: begin
                if (!pin_rst && !hot_level) begin
                    state_nxt = CTR_ST_RUN;
                end
            end
            CTR_ST_SETTLE, CTR_ST_RUN: begin
                if (hot_level || pin_rst || wdt_rst) begin
                    state_nxt = CTR_ST_RST;
                end else if (wdt_wake) begin
                    state_nxt = CTR_ST_SETTLE;
                end else if (state_r == CTR_ST_SETTLE
                             && cnt_r == SETTLE_LAST) begin
                    state_nxt = CTR_ST_RUN;
                end
            end
            default: state_nxt = CTR_ST_POR;
        endcase
    end

    // State register; the power-on hold is reached from power-on only.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_r <= CTR_ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // One counter serves the power-on hold and the settle wait; each stops
    // at its own end, so a short hold can never starve the settle count.
    always_ff @(posedge clock_i) begin
        if (srst_i || state_nxt != state_r || wdt_wake) begin
            cnt_r <= '0;
        end else if (state_r == CTR_ST_POR && cnt_r != SUPPLY_SETTLE_TIMER_LAST) begin
            cnt_r <= cnt_r + `CTR_CNT_W'(1);
        end else if (state_r == CTR_ST_SETTLE && cnt_r != SETTLE_LAST) begin
            cnt_r <= cnt_r + `CTR_CNT_W'(1);
        end
    end

    assign chip_reset_o = state_r == CTR_ST_POR || state_r == CTR_ST_RST;
    assign run_o = state_r == CTR_ST_RUN;

    // Sleep tracking; any reset or a wake ends the sleep.
    always_ff @(posedge clock_i) begin
        if (srst_i || chip_reset_o || wdt_wake) begin
            asleep_r <= 1'b0;
        end else if (sleep_enter_i) begin
            asleep_r <= 1'b1;
        end
    end

    // Cause flags: a thermal or awake pin reset leaves them unchanged.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            to_r <= 1'b1;
            pd_r <= 1'b1;
        end else if (wdt_wake) begin
            to_r <= 1'b0;
            pd_r <= 1'b0;
        end else if (wdt_rst && !chip_reset_o) begin
            to_r <= 1'b0;
        end else if (pin_rst && asleep_r) begin
            to_r <= 1'b1;
            pd_r <= 1'b0;
        end else if (sleep_enter_i) begin
            to_r <= 1'b1;
            pd_r <= 1'b0;
        end else if (watchdog_clear_i) begin
            to_r <= 1'b1;
            pd_r <= 1'b1;
        end
    end

    assign wr_trim = wr_i && hit(addr_i, `CTR_ADDR_TRIM);

    // User trim: cleared by every resetting source, not by a wake.
    always_ff @(posedge clock_i) begin
        if (srst_i || state_r == CTR_ST_RST) begin
            trim_r <= '0;
        end else if (wr_trim) begin
            trim_r <= wdata_i[`CTR_TRIM_W-1:0];
        end
    end

    // Trim base is left alone by pin, thermal and watchdog resets.
    // It is cleared at power-on only so simulation starts defined.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            base_r <= '0;
        end else if (wr_i && hit(addr_i, `CTR_ADDR_BASE)) begin
            base_r <= wdata_i[`CTR_BASE_W-1:0];
        end
    end

    assign clock_trim_base_o = base_r;

    // Applied trim walks toward the target in bounded signed steps, so
    // the largest swing finishes in seven clocks, under eight base cycles.
    always_comb begin
        diff = 6'($signed(trim_r)) - 6'(trim_applied_o);
        if (diff > STEP) begin
            applied_nxt = 6'(trim_applied_o) + STEP;
        end else if (diff < -STEP) begin
            applied_nxt = 6'(trim_applied_o) - STEP;
        end else begin
            applied_nxt = 6'($signed(trim_r));
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            trim_applied_o <= '0;
        end else begin
            trim_applied_o <= applied_nxt[`CTR_TRIM_W-1:0];
        end
    end

    // Events feeding the sticky interrupt status bits.
    assign ev[`CTR_EV_POR] = state_r == CTR_ST_POR
                             && state_nxt != CTR_ST_POR;
    assign ev[`CTR_EV_PIN] = pin_rst && !chip_reset_o;
    assign ev[`CTR_EV_WDT] = wdt_rst && !chip_reset_o;
    assign ev[`CTR_EV_WAKE] = wdt_wake;
    assign ev[`CTR_EV_HOT] = hot_level && !chip_reset_o;
    assign ev[`CTR_EV_TRIM] = 6'(trim_applied_o) != applied_nxt
                              && applied_nxt == 6'($signed(trim_r));

    // Sticky bits, cleared by writing one; a new event beats the clear.
    genvar gi;
    generate
        for (gi = 0; gi < `CTR_EV_W; gi++) begin : g_ist
            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    ist_r[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    ist_r[gi] <= 1'b1;
                end else if (wr_i && hit(addr_i, `CTR_ADDR_IST)
                             && wdata_i[gi]) begin
                    ist_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Interrupt mask register.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            imsk_r <= '0;
        end else if (wr_i && hit(addr_i, `CTR_ADDR_IMSK)) begin
            imsk_r <= wdata_i[`CTR_EV_W-1:0];
        end
    end

    assign irq_o = |(ist_r & imsk_r);

    // Read mux; unmapped addresses and unused bits read zero.
    always_comb begin
        rd_nxt = '0;
        case (1'b1)
            hit(addr_i, `CTR_ADDR_TRIM):
                rd_nxt[`CTR_TRIM_W-1:0] = trim_r;
            hit(addr_i, `CTR_ADDR_BASE):
                rd_nxt[`CTR_BASE_W-1:0] = base_r;
            hit(addr_i, `CTR_ADDR_CAL):
                rd_nxt[`CTR_CAL_W-1:0] = factory_calibration_word_i;
            hit(addr_i, `CTR_ADDR_FLAGS): begin
                rd_nxt[`CTR_FLAG_TO] = to_r;
                rd_nxt[`CTR_FLAG_PD] = pd_r;
                rd_nxt[`CTR_FLAG_ST+3:`CTR_FLAG_ST] = state_r;
            end
            hit(addr_i, `CTR_ADDR_IST): rd_nxt[`CTR_EV_W-1:0] = ist_r;
            hit(addr_i, `CTR_ADDR_IMSK): rd_nxt[`CTR_EV_W-1:0] = imsk_r;
            default: rd_nxt = '0;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clock_i) begin
        if (srst_i || !rd_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_nxt;
        end
    end

    logic signed [5:0] jump;
    assign jump = applied_nxt - 6'(trim_applied_o);

    // All checks share the system clock and rest while reset is held.
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    trim_zero_a: assert property (
        state_r == CTR_ST_RST |=> trim_r == '0)
        else $error("trim not cleared by reset");
    trim_ramp_a: assert property (
        $changed(trim_r) |-> ##[0:7] trim_applied_o == $signed(trim_r))
        else $error("trim did not settle in time");
    trim_step_a: assert property (
        jump <= STEP && jump >= -STEP)
        else $error("trim step too large");
    settle_len_a: assert property (
        $rose(run_o) && $past(state_r) == CTR_ST_SETTLE
        |-> $past(cnt_r) == SETTLE_LAST)
        else $error("settle wait wrong length");
    supply_settle_timer_hold_a: assert property (
        state_r == CTR_ST_POR && supply_settle_timer_en_i
        && cnt_r != SUPPLY_SETTLE_TIMER_LAST |=> chip_reset_o)
        else $error("reset released during power-up hold");
    wdt_wake_a: assert property (
        wdt_wake && run_o && !pin_rst && !hot_level
        |=> state_r == CTR_ST_SETTLE && !to_r && !pd_r)
        else $error("watchdog wake misbehaved");
    wdt_flag_a: assert property (
        wdt_rst && run_o |=> chip_reset_o && !to_r)
        else $error("watchdog reset flags wrong");
    pin_off_a: assert property (
        state_r == CTR_ST_RST && !external_reset_pin_select_i && !hot_level
        |=> run_o)
        else $error("deselected pin held reset");
    cal_read_a: assert property (
        rd_i && hit(addr_i, `CTR_ADDR_CAL) |=> rdata_o
        == `CTR_DW'($past(factory_calibration_word_i)))
        else $error("calibration word read wrong");
    base_keep_a: assert property (
        chip_reset_o && !wr_i |=> $stable(base_r))
        else $error("trim base lost in reset");

    supply_settle_timer_done_c: cover property (
        state_r == CTR_ST_POR ##1 state_r == CTR_ST_SETTLE);
    wake_c: cover property (wdt_wake);
    pin_sleep_c: cover property (pin_rst && asleep_r);
    trim_swing_c: cover property (ev[`CTR_EV_TRIM] ##1 irq_o);
endmodule : ctr_top

// ### test/ctr_top_bench.sv
// Self-checking bench for the clock trim and reset source block.
`timescale 1ns/1ps
`include "ctr_defs.svh"
module ctr_top_bench
    import ctr_pkg::*;
;
    // Short power-up hold keeps the run brief; delays derive from it.
    localparam int SUPPLY_SETTLE_TIMER = 20;
    localparam int SETTLE = 400;
    localparam logic [13:0] CAL = 14'h2A5B;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic pin_n = 1'b1;
    logic pin_sel = 1'b1;
    logic tmr_en = 1'b1;
    logic hot = 1'b0;
    logic wdt = 1'b0;
    logic wclr = 1'b0;
    logic slp = 1'b0;
    logic chip_reset_o;
    logic run_o;
    logic irq_o;
    logic [6:0] base_o;
    logic signed [4:0] trim_o;
    logic [15:0] rv;
    logic [4:0] codes [5] = '{5'h0F, 5'h10, 5'h00, 5'h1F, 5'h01};
    int n_mismatch = 0;
    int samples_checked = 0;
    int cy = 0;
    int t0 = 0;
    int d;
    int prev;

    // The clock runs at 40 MHz.
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    // A free cycle count lets delays be measured from any start point.
    always @(posedge clock_i) begin
        cy <= cy + 1;
    end

    ctr_top #(.SUPPLY_SETTLE_TIMER_CYC(SUPPLY_SETTLE_TIMER), .PIN_FILT(2)) i_ctr_top (
        .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .factory_calibration_word_i(CAL),
        .external_reset_pin_n_i(pin_n),
        .external_reset_pin_select_i(pin_sel),
        .supply_settle_timer_en_i(tmr_en), .thermal_fault_i(hot),
        .watchdog_expire_i(wdt), .watchdog_clear_i(wclr),
        .sleep_enter_i(slp), .chip_reset_o(chip_reset_o), .run_o(run_o),
        .clock_trim_base_o(base_o), .trim_applied_o(trim_o),
        .irq_o(irq_o)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Case inequality keeps an unknown from passing as a match.
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step

    // One-cycle write strobe; ends after the edge has landed.
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        rv = rdata_o;
    endtask : rd

    // Bounded wait for run, the delay measured from t0.
    task automatic wait_run(input int lo, input int hi);
        while (run_o !== 1'b1 && cy - t0 <= hi) begin
            step(1);
        end
        chk("run delay ok", 16'h1, {15'h0, cy - t0 >= lo && cy - t0 <= hi});
        if (run_o !== 1'b1) begin
            results();
        end
    endtask : wait_run

    task automatic wait_rst(input int n);
        while (chip_reset_o !== 1'b1 && n > 0) begin
            step(1);
            n--;
        end
        chk("reset seen", 16'h1, {15'h0, chip_reset_o === 1'b1});
        if (chip_reset_o !== 1'b1) begin
            results();
        end
    endtask : wait_rst

    task automatic pulse_wdt();
        @(posedge clock_i);
        wdt <= 1'b1;
        @(posedge clock_i);
        wdt <= 1'b0;
        #1;
    endtask : pulse_wdt

    initial begin
        repeat (8) @(posedge clock_i);
        srst_i <= 1'b0;
        t0 = cy + 1;
        #1;
        chk("chip reset", 16'h1, {15'h0, chip_reset_o});
        rd(8'h0C);
        chk("flags por", {8'h0, CTR_ST_POR, 4'h3}, rv);
        rd(8'h00);
        chk("trim reset", 16'h0, rv);
        wait_run(SUPPLY_SETTLE_TIMER + SETTLE - 1, SUPPLY_SETTLE_TIMER + SETTLE + 8);
        rd(8'h10);
        chk("por status", 16'h1, rv & 16'h1);
        rd(8'h08);
        chk("cal word", {2'b0, CAL}, rv);
        wr(8'h08, 16'h0000);
        rd(8'h08);
        chk("cal kept", {2'b0, CAL}, rv);
        wr(8'h04, {9'h0, CAL[6:0]});
        rd(8'h04);
        chk("base", {9'h0, CAL[6:0]}, rv);
        chk("base out", {9'h0, CAL[6:0]}, {9'h0, base_o});
        wr(8'h00, 16'hFFFF);
        rd(8'h00);
        chk("trim bits", 16'h001F, rv);
        rd(8'h20);
        chk("unmapped", 16'h0, rv);
        $display("test registers done");
        // Each code must be approached without overshoot.
        foreach (codes[k]) begin
            wr(8'h00, {11'h0, codes[k]});
            prev = 99;
            repeat (8) begin
                d = $signed(codes[k]) - trim_o;
                d = (d < 0) ? -d : d;
                chk("ramp step", 16'h1, {15'h0, d <= prev});
                prev = d;
                step(1);
            end
            chk("ramp end", 16'(codes[k]), {11'h0, trim_o});
        end
        $display("test trim ramp done");
        wr(8'h10, 16'h003F);
        chk("irq idle", 16'h0, {15'h0, irq_o});
        wr(8'h14, 16'h0020);
        wr(8'h00, 16'h0003);
        step(8);
        chk("irq set", 16'h1, {15'h0, irq_o});
        wr(8'h14, 16'h0000);
        chk("irq masked", 16'h0, {15'h0, irq_o});
        wr(8'h14, 16'h0020);
        chk("irq unmasked", 16'h1, {15'h0, irq_o});
        wr(8'h10, 16'h0020);
        chk("irq cleared", 16'h0, {15'h0, irq_o});
        $display("test interrupt done");
        pulse_wdt();
        wait_rst(4);
        t0 = cy;
        wait_run(0, 4);
        rd(8'h0C);
        chk("flags wdt", {8'h0, CTR_ST_RUN, 4'h2}, rv);
        rd(8'h00);
        chk("trim wdt", 16'h0, rv);
        rd(8'h04);
        chk("base kept", {9'h0, CAL[6:0]}, rv);
        rd(8'h10);
        chk("wdt status", 16'h4, rv & 16'h4);
        $display("test watchdog reset done");
        wr(8'h00, 16'h0005);
        @(posedge clock_i);
        slp <= 1'b1;
        @(posedge clock_i);
        slp <= 1'b0;
        rd(8'h0C);
        chk("flags sleep", 16'h1, rv & 16'h3);
        pulse_wdt();
        step(1);
        chk("wake no reset", 16'h0, {15'h0, chip_reset_o});
        chk("wake settle", 16'h0, {15'h0, run_o});
        t0 = cy;
        wait_run(SETTLE - 4, SETTLE + 4);
        rd(8'h0C);
        chk("flags wake", {8'h0, CTR_ST_RUN, 4'h0}, rv);
        rd(8'h00);
        chk("trim wake", 16'h5, rv);
        rd(8'h10);
        chk("wake status", 16'h8, rv & 16'h8);
        @(posedge clock_i);
        wclr <= 1'b1;
        @(posedge clock_i);
        wclr <= 1'b0;
        rd(8'h0C);
        chk("flags clear", {8'h0, CTR_ST_RUN, 4'h3}, rv);
        $display("test watchdog wake done");
        // A one-cycle glitch on the pin must be swallowed.
        @(posedge clock_i);
        pin_n <= 1'b0;
        @(posedge clock_i);
        pin_n <= 1'b1;
        step(10);
        chk("glitch", 16'h0, {15'h0, chip_reset_o});
        // Pin reset taken while asleep: watchdog flag set, sleep flag clear.
        @(posedge clock_i);
        slp <= 1'b1;
        @(posedge clock_i);
        slp <= 1'b0;
        pin_n <= 1'b0;
        wait_rst(10);
        step(5);
        chk("pin held", 16'h1, {15'h0, chip_reset_o});
        @(posedge clock_i);
        pin_n <= 1'b1;
        t0 = cy;
        wait_run(0, 12);
        rd(8'h10);
        chk("pin status", 16'h2, rv & 16'h2);
        rd(8'h00);
        chk("trim pin", 16'h0, rv);
        rd(8'h0C);
        chk("flags pin sleep", {8'h0, CTR_ST_RUN, 4'h1}, rv);
        // Deselecting a held pin must release the chip at once.
        @(posedge clock_i);
        pin_n <= 1'b0;
        wait_rst(10);
        @(posedge clock_i);
        pin_sel <= 1'b0;
        t0 = cy;
        wait_run(0, 4);
        step(12);
        chk("pin ignored", 16'h0, {15'h0, chip_reset_o});
        // Release the pin before selecting it again, or the filtered low
        // level still in the filter would reset the chip.
        @(posedge clock_i);
        pin_n <= 1'b1;
        step(8);
        @(posedge clock_i);
        pin_sel <= 1'b1;
        step(8);
        chk("pin sel back", 16'h0, {15'h0, chip_reset_o});
        $display("test reset pin done");
        @(posedge clock_i);
        hot <= 1'b1;
        wait_rst(8);
        step(4);
        chk("hot held", 16'h1, {15'h0, chip_reset_o});
        @(posedge clock_i);
        hot <= 1'b0;
        t0 = cy;
        wait_run(0, 10);
        rd(8'h10);
        chk("hot status", 16'h10, rv & 16'h10);
        $display("test thermal done");
        // Power-on again with the hold timer off: only the settle delay.
        @(posedge clock_i);
        srst_i <= 1'b1;
        tmr_en <= 1'b0;
        repeat (4) @(posedge clock_i);
        srst_i <= 1'b0;
        t0 = cy + 1;
        rd(8'h04);
        chk("base por", 16'h0, rv);
        wait_run(SETTLE - 1, SETTLE + 8);
        $display("test second power-on done");
        results();
    end
endmodule : ctr_top_bench
